// ---- logic/irq_params.svh ----
// Register addresses, field positions, reset values and vector addresses of the interrupt controller.
`ifndef IRQ_PARAMS_SVH
`define IRQ_PARAMS_SVH
`define ADDR_ENABLE_BANK_ZERO 8'ha8
`define ADDR_PRIORITY_BANK_ZERO 8'hb8
`define ADDR_REQUEST_FLAGS 8'hc0
`define ADDR_ENABLE_BANK_ONE 8'he8
`define ADDR_POLARITY_SELECT 8'he9
`define ADDR_PRIORITY_BANK_ONE 8'hf8
`define RESET_VALUE_REG 8'h00
`define BIT_GLOBAL_IRQ_ENABLE 7
`define BIT_SERIAL_BUS 5
`define BIT_TIMER_ONE 3
`define BIT_EXT_ONE 2
`define BIT_TIMER_ZERO 1
`define BIT_EXT_ZERO 0
`define BIT_PORT_BIT7 7
`define BIT_VSYNC 5
`define MASK_FLAGS 8'hbf
`define VEC_EXT_ZERO 16'h0003
`define VEC_TIMER_ZERO 16'h000b
`define VEC_EXT_ONE 16'h0013
`define VEC_TIMER_ONE 16'h001b
`define VEC_SERIAL_BUS 16'h002b
`define VEC_PORT_BIT0 16'h0033
`define VEC_PORT_BIT1 16'h003b
`define VEC_PORT_BIT2 16'h0043
`define VEC_PORT_BIT3 16'h004b
`define VEC_PORT_BIT4 16'h005b
`define VEC_VSYNC 16'h0063
`define VEC_PORT_BIT7 16'h0073
`endif

// ---- logic/irq_pkg.sv ----
// Types shared by the interrupt controller and its users.
package irq_pkg;
  // One special function register access from the CPU core.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;
  // Source numbers in fixed order within a level, first is served first.
  typedef enum logic [3:0] {
    SRC_EXT_ZERO, SRC_SERIAL_BUS, SRC_TIMER_ZERO, SRC_PORT_BIT0, SRC_PORT_BIT4, SRC_EXT_ONE,
    SRC_PORT_BIT1, SRC_VSYNC, SRC_TIMER_ONE, SRC_PORT_BIT2, SRC_PORT_BIT3, SRC_PORT_BIT7
  } src_id_t;
endpackage

// ---- logic/two_level_vectored_interrupt_controller.sv ----
// Twelve-source, two-level, nested vectored interrupt controller with its special function registers.
`timescale 1ns/1ns
`include "irq_params.svh"

module two_level_vectored_interrupt_controller
  import irq_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Special function register access from the core.
  input sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  // Request levels of the core's own sources.
  input wire logic ext_irq_pin_zero,
  input wire logic ext_irq_pin_one,
  input wire logic timer_zero_source,
  input wire logic timer_one_source,
  input wire logic serial_bus_source,
  // Port one pins and the vertical sync interrupt line.
  input wire logic [7:0] port_pins,
  input wire logic vsync_irq_line,
  // Vector hand-off to the CPU core.
  output logic irq_req,
  output logic [15:0] irq_vector,
  output logic irq_high,
  input wire logic irq_ack,
  input wire logic irq_return,
  // Nesting state.
  output logic in_low_routine,
  output logic in_high_routine
);

  // Software-visible registers.
  logic [7:0] enable_bank_zero_r;
  logic [7:0] enable_bank_one_r;
  logic [7:0] priority_bank_zero_r;
  logic [7:0] priority_bank_one_r;
  logic [7:0] polarity_select_r;
  logic [7:0] request_flags_r;
  logic [7:0] request_flags_nxt;
  // Live source conditions, enables, priorities in arbitration order.
  logic [7:0] port_cond;
  logic [11:0] src_req;
  logic [11:0] src_en;
  logic [11:0] src_prio;
  logic [11:0] hi_pend;
  logic [11:0] lo_pend;
  // Arbitration result.
  logic win_valid;
  logic win_high;
  logic [3:0] win_idx;
  // Registered hand-off state.
  logic irq_req_r;
  logic irq_high_r;
  logic [3:0] irq_idx_r;
  logic [15:0] irq_vector_r;
  logic in_low_r;
  logic in_high_r;
  logic [7:0] sfr_rdata_r;

  // Returns the first set source in fixed order, or all ones if none.
  function automatic logic [3:0] first_set(input logic [11:0] m);
    logic [3:0] idx;
    idx = 4'hf;
    for (int i = 11; i >= 0; i--) begin
      if (m[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // Maps a source number to its program-memory vector.
  function automatic logic [15:0] vector_of(input logic [3:0] idx);
    logic [15:0] v;
    v = `VEC_EXT_ZERO;
    case (idx)
      SRC_EXT_ZERO: v = `VEC_EXT_ZERO;
      SRC_SERIAL_BUS: v = `VEC_SERIAL_BUS;
      SRC_TIMER_ZERO: v = `VEC_TIMER_ZERO;
      SRC_EXT_ONE: v = `VEC_EXT_ONE;
      SRC_TIMER_ONE: v = `VEC_TIMER_ONE;
      SRC_PORT_BIT0: v = `VEC_PORT_BIT0;
      SRC_PORT_BIT1: v = `VEC_PORT_BIT1;
      SRC_PORT_BIT2: v = `VEC_PORT_BIT2;
      SRC_PORT_BIT3: v = `VEC_PORT_BIT3;
      SRC_PORT_BIT4: v = `VEC_PORT_BIT4;
      SRC_VSYNC: v = `VEC_VSYNC;
      SRC_PORT_BIT7: v = `VEC_PORT_BIT7;
      default: v = `VEC_EXT_ZERO;
    endcase
    return v;
  endfunction

  // Pin conditions: port pins 0 to 4 and 7 request when equal to their polarity bit; pins 5 and 6 never do; vsync is fixed active-high.
  always_comb begin
    port_cond = ~(port_pins ^ polarity_select_r);
    port_cond[6] = 1'b0;
    port_cond[5] = vsync_irq_line;
    port_cond[7] = ~(port_pins[7] ^ polarity_select_r[7]);
  end

  // Flags: a condition sets its flag whatever the enable; a write stores data but the set wins.
  always_comb begin
    request_flags_nxt = request_flags_r;
    if (sfr_req.wr && sfr_req.addr == `ADDR_REQUEST_FLAGS) begin
      request_flags_nxt = sfr_req.wdata;
    end
    request_flags_nxt = (request_flags_nxt | port_cond) & `MASK_FLAGS;
  end

  // Gathers requests, enables and priority bits in arbitration order.
  always_comb begin
    src_req = {request_flags_r[7], request_flags_r[3], request_flags_r[2], timer_one_source,
               request_flags_r[5], request_flags_r[1], ext_irq_pin_one, request_flags_r[4],
               request_flags_r[0], timer_zero_source, serial_bus_source, ext_irq_pin_zero};
    src_en = {enable_bank_one_r[7], enable_bank_one_r[3], enable_bank_one_r[2], enable_bank_zero_r[3],
              enable_bank_one_r[5], enable_bank_one_r[1], enable_bank_zero_r[2], enable_bank_one_r[4],
              enable_bank_one_r[0], enable_bank_zero_r[1], enable_bank_zero_r[5], enable_bank_zero_r[0]};
    src_prio = {priority_bank_one_r[7], priority_bank_one_r[3], priority_bank_one_r[2], priority_bank_zero_r[3],
                priority_bank_one_r[5], priority_bank_one_r[1], priority_bank_zero_r[2], priority_bank_one_r[4],
                priority_bank_one_r[0], priority_bank_zero_r[1], priority_bank_zero_r[5],
                priority_bank_zero_r[0]};
    hi_pend = src_req & src_en & src_prio & {12{enable_bank_zero_r[`BIT_GLOBAL_IRQ_ENABLE]}};
    lo_pend = src_req & src_en & ~src_prio & {12{enable_bank_zero_r[`BIT_GLOBAL_IRQ_ENABLE]}};
  end

  // Chooses the winner: high level first, nesting decides what may preempt.
  always_comb begin
    win_valid = 1'b0;
    win_high = 1'b0;
    win_idx = 4'hf;
    if (in_high_r) begin
      // A high routine is never interrupted.
      win_valid = 1'b0;
    end else if (|hi_pend) begin
      // High requests win and may preempt a low routine.
      win_valid = 1'b1;
      win_high = 1'b1;
      win_idx = first_set(hi_pend);
    end else if (!in_low_r && |lo_pend) begin
      // Low requests wait while a low routine runs.
      win_valid = 1'b1;
      win_idx = first_set(lo_pend);
    end
  end

  // Register writes from the core.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      enable_bank_zero_r <= `RESET_VALUE_REG;
      enable_bank_one_r <= `RESET_VALUE_REG;
      priority_bank_zero_r <= `RESET_VALUE_REG;
      priority_bank_one_r <= `RESET_VALUE_REG;
      polarity_select_r <= `RESET_VALUE_REG;
    end else if (sfr_req.wr) begin
      case (sfr_req.addr)
        `ADDR_ENABLE_BANK_ZERO: enable_bank_zero_r <= sfr_req.wdata & 8'haf;
        `ADDR_ENABLE_BANK_ONE: enable_bank_one_r <= sfr_req.wdata & 8'hbf;
        `ADDR_PRIORITY_BANK_ZERO: priority_bank_zero_r <= sfr_req.wdata & 8'h2f;
        `ADDR_PRIORITY_BANK_ONE: priority_bank_one_r <= sfr_req.wdata & 8'hbf;
        `ADDR_POLARITY_SELECT: polarity_select_r <= sfr_req.wdata;
        default: ;
      endcase
    end
  end

  // Request flag register.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      request_flags_r <= `RESET_VALUE_REG;
    end else begin
      request_flags_r <= request_flags_nxt;
    end
  end

  // Read data, registered; unmapped addresses read zero.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sfr_rdata_r <= 8'h00;
    end else if (sfr_req.rd) begin
      case (sfr_req.addr)
        `ADDR_ENABLE_BANK_ZERO: sfr_rdata_r <= enable_bank_zero_r;
        `ADDR_ENABLE_BANK_ONE: sfr_rdata_r <= enable_bank_one_r;
        `ADDR_PRIORITY_BANK_ZERO: sfr_rdata_r <= priority_bank_zero_r;
        `ADDR_PRIORITY_BANK_ONE: sfr_rdata_r <= priority_bank_one_r;
        `ADDR_POLARITY_SELECT: sfr_rdata_r <= polarity_select_r;
        `ADDR_REQUEST_FLAGS: sfr_rdata_r <= request_flags_r;
        default: sfr_rdata_r <= 8'h00;
      endcase
    end
  end

  // Offer to the core; dropped for one cycle after an accept so nesting state can settle.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_req_r <= 1'b0;
      irq_high_r <= 1'b0;
      irq_idx_r <= 4'hf;
      irq_vector_r <= 16'h0000;
    end else begin
      irq_req_r <= win_valid && !irq_ack;
      irq_high_r <= win_high;
      irq_idx_r <= win_idx;
      irq_vector_r <= vector_of(win_idx);
    end
  end

  // Nesting state: an accept enters the offered level, a return leaves the innermost one.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      in_low_r <= 1'b0;
      in_high_r <= 1'b0;
    end else if (irq_ack && irq_req_r) begin
      if (irq_high_r) begin
        in_high_r <= 1'b1;
      end else begin
        in_low_r <= 1'b1;
      end
    end else if (irq_return) begin
      if (in_high_r) begin
        in_high_r <= 1'b0;
      end else begin
        in_low_r <= 1'b0;
      end
    end
  end

  // Outputs.
  assign sfr_rdata = sfr_rdata_r;
  assign irq_req = irq_req_r;
  assign irq_high = irq_high_r;
  assign irq_vector = irq_vector_r;
  assign in_low_routine = in_low_r;
  assign in_high_routine = in_high_r;

  // Checks.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire flag_wr = sfr_req.wr && sfr_req.addr == `ADDR_REQUEST_FLAGS;
  property p_flag_sticky;
    request_flags_r[0] && !flag_wr |=> request_flags_r[0];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without write");
  property p_flag_disabled;
    !enable_bank_one_r[0] && port_pins[0] == polarity_select_r[0] |=> request_flags_r[0];
  endproperty
  a_flag_disabled: assert property (p_flag_disabled) else $error("flag not set while disabled");
  property p_vsync_fixed;
    vsync_irq_line |=> request_flags_r[5];
  endproperty
  a_vsync_fixed: assert property (p_vsync_fixed) else $error("vsync flag not set");
  property p_high_wins;
    |hi_pend && |lo_pend && !in_high_r && !irq_ack |=> irq_req && irq_high;
  endproperty
  a_high_wins: assert property (p_high_wins) else $error("high request lost to low");
  property p_low_waits;
    in_low_r && irq_req |-> irq_high;
  endproperty
  a_low_waits: assert property (p_low_waits) else $error("low request preempted low routine");
  property p_high_locked;
    in_high_r ##1 in_high_r |-> !irq_req;
  endproperty
  a_high_locked: assert property (p_high_locked) else $error("request during high routine");
  property p_global_off;
    !enable_bank_zero_r[`BIT_GLOBAL_IRQ_ENABLE] |=> !irq_req;
  endproperty
  a_global_off: assert property (p_global_off) else $error("request with global enable off");
  property p_order;
    src_req[0] && src_req[8] && src_en[0] && src_en[8] && src_prio[0] == src_prio[8] |=> irq_vector != `VEC_TIMER_ONE;
  endproperty
  a_order: assert property (p_order) else $error("fixed order violated");
  property p_vector;
    irq_req && irq_idx_r == 4'h7 |-> irq_vector == `VEC_VSYNC;
  endproperty
  a_vector: assert property (p_vector) else $error("wrong vsync vector");
  c_preempt: cover property (in_low_r && irq_req && irq_high);
  c_nest: cover property (in_low_r && in_high_r);
  c_flag_clear: cover property (request_flags_r[7] ##1 !request_flags_r[7]);

endmodule // two_level_vectored_interrupt_controller

// ---- tb/cpu_core_model.sv ----
// CPU core model that takes offered vectors and returns from routines on command.
`timescale 1ns/1ns
module cpu_core_model (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Offer from the controller.
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  // Behaviour chosen by the bench.
  input wire logic ack_en,
  input wire logic [3:0] ack_wait,
  input wire logic ret_go,
  // Answers to the controller.
  output logic irq_ack,
  output logic irq_return,
  output logic [15:0] taken_vector
);
  logic [3:0] wait_r; // Cycles the current offer has been seen.
  // Take an offer after the chosen wait; one pulse, then stand back so it is not taken twice.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_ack <= 1'b0;
      wait_r <= 4'h0;
      taken_vector <= 16'h0000;
    end else if (irq_ack) begin
      irq_ack <= 1'b0;
      wait_r <= 4'h0;
    end else if (irq_req && ack_en) begin
      if (wait_r == ack_wait) begin
        irq_ack <= 1'b1;
        taken_vector <= irq_vector;
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end else begin
      wait_r <= 4'h0;
    end
  end
  // The return pulse follows the bench command by one cycle.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_return <= 1'b0;
    end else begin
      irq_return <= ret_go;
    end
  end
endmodule // cpu_core_model

// ---- tb/tb_top.sv ----
// Self-checking bench for the two-level vectored interrupt controller.
`timescale 1ns/1ns
module tb_top;
  import irq_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  sfr_req_t sfr_req = '0;
  logic [7:0] sfr_rdata;
  logic [11:0] src = 12'h000; // Active sources, indexed in fixed order.
  logic irq_req, irq_high, irq_ack, irq_return, in_low_routine, in_high_routine;
  logic [15:0] irq_vector, taken_vector;
  logic ack_en = 1'b0;
  logic [3:0] ack_wait = 4'h0;
  logic ret_go = 1'b0;
  int fails = 0;
  int check_count = 0;
  logic [15:0] vec [12] = '{16'h0003, 16'h002b, 16'h000b, 16'h0033, 16'h005b, 16'h0013,
                            16'h003b, 16'h0063, 16'h001b, 16'h0043, 16'h004b, 16'h0073};
  logic [7:0] adr [6] = '{8'ha8, 8'hb8, 8'hc0, 8'he8, 8'he9, 8'hf8};
  logic [7:0] msk [6] = '{8'haf, 8'h2f, 8'hbf, 8'hbf, 8'hff, 8'hbf};
  // The clock toggles every half period of 20 ns.
  always #20 clock = ~clock;
  two_level_vectored_interrupt_controller dut_u (.clock(clock), .reset_n(reset_n), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .ext_irq_pin_zero(src[0]), .ext_irq_pin_one(src[5]), .timer_zero_source(src[2]),
    .timer_one_source(src[8]), .serial_bus_source(src[1]), .vsync_irq_line(src[7]),
    .port_pins({src[11], 2'b00, src[4], src[10], src[9], src[6], src[3]}), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_high(irq_high), .irq_ack(irq_ack), .irq_return(irq_return),
    .in_low_routine(in_low_routine), .in_high_routine(in_high_routine));
  cpu_core_model core_u (.clock(clock), .reset_n(reset_n), .irq_req(irq_req), .irq_vector(irq_vector),
    .ack_en(ack_en), .ack_wait(ack_wait), .ret_go(ret_go), .irq_ack(irq_ack), .irq_return(irq_return),
    .taken_vector(taken_vector));
  // Reports the verdict and ends the run.
  task automatic give_verdict;
    if (fails == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Compares a seen value with the expected one.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Register write and read, one strobe cycle each.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock) sfr_req <= '{1'b1, 1'b0, a, d};
    @(posedge clock) sfr_req <= '0;
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock) sfr_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clock) sfr_req <= '0;
    #1 check(sfr_rdata, e);
  endtask
  // Sources are held for many cycles, well past the minimum width.
  task automatic drv(input logic [11:0] s);
    @(posedge clock) src <= s;
  endtask
  // Waits a bounded time for an offer and checks it.
  task automatic offer(input logic [15:0] v, input logic h);
    int k;
    // Step off the edge so that values launched on it have settled.
    #1;
    for (k = 0; k < 12 && irq_req !== 1'b1; k++) begin
      @(posedge clock);
      #1;
    end
    check({irq_req, irq_high, irq_vector}, {1'b1, h, v});
  endtask
  task automatic take(input logic [3:0] w, input logic hi, input logic lo);
    int k;
    @(posedge clock) ack_wait <= w;
    ack_en <= 1'b1;
    for (k = 0; k < 12 && irq_ack !== 1'b1; k++) begin
      @(posedge clock);
      #1;
    end
    @(posedge clock) ack_en <= 1'b0;
    #1 check({in_high_routine, in_low_routine}, {hi, lo});
  endtask
  task automatic ret(input logic hi, input logic lo);
    @(posedge clock) ret_go <= 1'b1;
    @(posedge clock) ret_go <= 1'b0;
    @(posedge clock);
    #1 check({in_high_routine, in_low_routine}, {hi, lo});
  endtask
  // Reset values, write masks and an unmapped address.
  task automatic t_regs;
    int i;
    // Reset polarity is active-low and the port pins idle low, so the port flags are already set.
    for (i = 0; i < 6; i++) chk(adr[i], (i == 2) ? 8'h9f : 8'h00);
    for (i = 0; i < 6; i++) begin
      wr(adr[i], 8'hff);
      chk(adr[i], msk[i]);
    end
    wr(8'h81, 8'hff);
    chk(8'h81, 8'h00);
    for (i = 0; i < 6; i++) if (i != 4) wr(adr[i], 8'h00);
    chk(8'hc0, 8'h00);
  endtask
  // Flags follow polarity, stay set, and ignore enables.
  task automatic t_flags;
    drv(12'h008);
    cyc(3);
    chk(8'hc0, 8'h01);
    check(irq_req, 1'b0);
    drv(12'h000);
    cyc(3);
    chk(8'hc0, 8'h01);
    wr(8'he9, 8'hfe);
    wr(8'hc0, 8'h00);
    chk(8'hc0, 8'h01);
    wr(8'he9, 8'hff);
    wr(8'hc0, 8'h00);
    chk(8'hc0, 8'h00);
    drv(12'he58);
    wr(8'he9, 8'h00);
    wr(8'hc0, 8'h00);
    cyc(2);
    chk(8'hc0, 8'h00);
    drv(12'hed8);
    cyc(3);
    chk(8'hc0, 8'h20);
    wr(8'he9, 8'hff);
    drv(12'h000);
    wr(8'hc0, 8'h00);
  endtask
  // Order within a level, every vector, and the global enable.
  task automatic t_order;
    int i;
    wr(8'ha8, 8'haf);
    wr(8'he8, 8'hbf);
    for (i = 0; i < 12; i++) begin
      drv(12'hfff << i);
      wr(8'hc0, 8'h00);
      cyc(3);
      #1 check({irq_req, irq_high, irq_vector}, {2'b10, vec[i]});
    end
    drv(12'h000);
    wr(8'hc0, 8'h00);
    wr(8'ha8, 8'h2f);
    drv(12'h001);
    cyc(4);
    #1 check(irq_req, 1'b0);
    wr(8'ha8, 8'haf);
    offer(16'h0003, 1'b0);
    // A core source raised to the high level wins over an earlier low one.
    drv(12'h101);
    wr(8'hb8, 8'h08);
    cyc(2);
    offer(16'h001b, 1'b1);
    wr(8'hb8, 8'h00);
  endtask
  // Levels, preemption and nesting with prompt and slow acknowledges.
  task automatic t_nest;
    drv(12'hfff);
    wr(8'hf8, 8'h80);
    cyc(2);
    offer(16'h0073, 1'b1);
    take(4'h3, 1'b1, 1'b0);
    check(taken_vector, 16'h0073);
    cyc(4);
    #1 check(irq_req, 1'b0);
    drv(12'h001);
    wr(8'hc0, 8'h00);
    ret(1'b0, 1'b0);
    offer(16'h0003, 1'b0);
    take(4'h0, 1'b0, 1'b1);
    cyc(4);
    #1 check(irq_req, 1'b0);
    drv(12'h801);
    offer(16'h0073, 1'b1);
    take(4'h1, 1'b1, 1'b1);
    ret(1'b0, 1'b1);
  endtask
  // Main sequence.
  initial begin
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    t_regs;
    t_flags;
    t_order;
    t_nest;
    give_verdict;
  end
  // Watchdog well beyond the expected length of the run.
  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    give_verdict;
  end
endmodule // tb_top
